// ===== design/rsc_defs.svh
// Register indexes, reset values and timing counts of the reset source control
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH
`define RSC_IDX_IFB0 10'h018
`define RSC_IDX_IFB1 10'h019
`define RSC_IDX_IFB2 10'h01A
`define RSC_IDX_IFB3 10'h01B
`define RSC_IDX_WDSVC 10'h020
`define RSC_IDX_WDCTL 10'h021
`define RSC_IDX_CMCTL 10'h022
`define RSC_IDX_RSTAT 10'h023
`define RSC_IDX_PRIO 10'h024
`define RSC_WD_KEY1 8'h55
`define RSC_WD_KEY2 8'hAA
`define RSC_WD_RATE_RST 3'h7
`define RSC_WD_WIN_BIT 6
`define RSC_PRIO_RST 8'hF2
`define RSC_OSC_WAIT_CYC 13'h1000
`define RSC_HOLD_CYC 13'h0010
`define RSC_SAMPLE_ECYC 13'h0009
`define RSC_REG_BASE 16'h0000
`define RSC_RAM_BASE 16'h2000
`define RSC_EE_BASE 16'h0800
`define RSC_MODE_RST 3'h4
`define RSC_WD_BASE_SH 10
`endif

// ===== design/rsc_pkg.sv
// Types shared by the reset source control
package rsc_pkg;
  typedef enum logic [2:0] {
    RSC_RUN = 3'b000,
    RSC_OSCWAIT = 3'b001,
    RSC_HOLD = 3'b010,
    RSC_SETTLE = 3'b011,
    RSC_EXTWAIT = 3'b100
  } rsc_seq_e;
  typedef enum logic [1:0] {
    RSC_SRC_POR = 2'b00,
    RSC_SRC_EXT = 2'b01,
    RSC_SRC_WDOG = 2'b10,
    RSC_SRC_CLKMON = 2'b11
  } rsc_src_e;
  typedef enum logic [1:0] {
    RSC_VEC_NORMAL = 2'b00,
    RSC_VEC_WDOG = 2'b01,
    RSC_VEC_CLKMON = 2'b10
  } rsc_vec_e;
endpackage

// ===== design/rsc_reset_source_control.sv
// Reset sources, reset pin sequencer, software watchdog and interrupt test registers
`timescale 1ns/10ps
`default_nettype none
`include "rsc_defs.svh"
module rsc_reset_source_control
  import rsc_pkg::*;
#(
  parameter int WD_BASE_SH = `RSC_WD_BASE_SH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe,
  input wire logic backgroundDebugPin,
  input wire logic modeSelectA,
  input wire logic modeSelectB,
  input wire logic clockSlow,
  input wire logic [31:0] moduleIrq,
  output logic [31:0] forcedIrq,
  output logic chipReset,
  output logic [1:0] resetVector,
  output logic [2:0] modeBits,
  output logic addrDataBusEn,
  output logic busControlEn,
  output logic portsAllInputs,
  output logic [15:0] regBlockBase,
  output logic [15:0] ramBase,
  output logic [15:0] eepromBase,
  output logic periodicIntFlag,
  output logic [3:0] periodicRate,
  output logic stopRecoveryDelay,
  output logic [7:0] topPriority,
  output logic irqEdgeSelect,
  output logic xMask,
  output logic iMask,
  output logic stopDisable,
  output logic [6:0] periphEnable
);
  rsc_seq_e seq_r;
  rsc_src_e src_r;
  logic [12:0] seqCnt_r;
  logic chipReset_r;
  logic pinDrive_r;
  logic [1:0] vec_r;
  logic [2:0] mode_r;
  logic eTick_r;
  logic [1:0] pinSync_r, dbgSync_r, selASync_r, selBSync_r, slowSync_r;
  logic pinLow;
  logic specialMode;
  logic [2:0] wdRate_r;
  logic wdWin_r;
  logic cmEn_r;
  logic [7:0] topPrio_r;
  logic [31:0] itst_r;
  logic [23:0] wdCnt_r;
  logic wdArmed_r;
  logic wdFault_r;
  logic wdEn;
  logic [23:0] wdPeriod;
  logic [23:0] wdWinStart;
  logic clkMonFault;
  logic [9:0] idx;
  logic aligned;
  logic mapped;
  logic wrAcc;
  logic [7:0] wrByte;
  logic [31:0] rdVal;
  logic [31:0] prdata_r;
  logic [31:0] itstView;

  // Pins come from outside the clock domain
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pinSync_r <= 2'h3;
      dbgSync_r <= 2'h3;
      selASync_r <= 2'h0;
      selBSync_r <= 2'h0;
      slowSync_r <= 2'h0;
    end else begin
      pinSync_r <= {pinSync_r[0], resetPinIn};
      dbgSync_r <= {dbgSync_r[0], backgroundDebugPin};
      selASync_r <= {selASync_r[0], modeSelectA};
      selBSync_r <= {selBSync_r[0], modeSelectB};
      slowSync_r <= {slowSync_r[0], clockSlow};
    end
  end

  assign pinLow = ~pinSync_r[1];
  assign specialMode = ~mode_r[2];

  // Bus clock enable, half the reference rate
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      eTick_r <= 1'b0;
    end else begin
      eTick_r <= ~eTick_r;
    end
  end

  assign clkMonFault = cmEn_r & slowSync_r[1];

  // Reset sequencer; power-on lands straight in the pin hold phase
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seq_r <= RSC_HOLD;
      src_r <= RSC_SRC_POR;
      seqCnt_r <= 13'h0000;
      chipReset_r <= 1'b1;
      pinDrive_r <= 1'b1;
      vec_r <= RSC_VEC_NORMAL;
    end else begin
      case (seq_r)
        RSC_RUN: begin
          seqCnt_r <= 13'h0000;
          if (clkMonFault) begin
            seq_r <= RSC_OSCWAIT;
            src_r <= RSC_SRC_CLKMON;
            chipReset_r <= 1'b1;
            pinDrive_r <= 1'b1;
          end else if (wdFault_r) begin
            seq_r <= RSC_HOLD;
            src_r <= RSC_SRC_WDOG;
            chipReset_r <= 1'b1;
            pinDrive_r <= 1'b1;
          end else if (pinLow) begin
            seq_r <= RSC_HOLD;
            src_r <= RSC_SRC_EXT;
            chipReset_r <= 1'b1;
            pinDrive_r <= 1'b1;
          end
        end
        RSC_OSCWAIT: begin
          if (seqCnt_r == `RSC_OSC_WAIT_CYC - 13'h0001) begin
            seq_r <= RSC_HOLD;
            seqCnt_r <= 13'h0000;
          end else begin
            seqCnt_r <= seqCnt_r + 13'h0001;
          end
        end
        RSC_HOLD: begin
          if (seqCnt_r == `RSC_HOLD_CYC - 13'h0001) begin
            seq_r <= RSC_SETTLE;
            seqCnt_r <= 13'h0000;
            pinDrive_r <= 1'b0;
          end else begin
            seqCnt_r <= seqCnt_r + 13'h0001;
          end
        end
        RSC_SETTLE: begin
          if (eTick_r) begin
            seqCnt_r <= seqCnt_r + 13'h0001;
            if (seqCnt_r == `RSC_SAMPLE_ECYC - 13'h0001) begin
              if (pinLow) begin
                src_r <= RSC_SRC_EXT;
                seq_r <= RSC_EXTWAIT;
              end else begin
                seq_r <= RSC_RUN;
                chipReset_r <= 1'b0;
                case (src_r)
                  RSC_SRC_WDOG: vec_r <= RSC_VEC_WDOG;
                  RSC_SRC_CLKMON: vec_r <= RSC_VEC_CLKMON;
                  default: vec_r <= RSC_VEC_NORMAL;
                endcase
              end
            end
          end
        end
        RSC_EXTWAIT: begin
          // Stays in reset for as long as the outside circuit holds the pin
          if (!pinLow) begin
            seq_r <= RSC_RUN;
            chipReset_r <= 1'b0;
            vec_r <= RSC_VEC_NORMAL;
          end
        end
        default: begin
          seq_r <= RSC_HOLD;
          seqCnt_r <= 13'h0000;
          chipReset_r <= 1'b1;
          pinDrive_r <= 1'b1;
        end
      endcase
    end
  end

  // Mode pins caught on the cycle the chip leaves reset
  logic modeLatch;
  assign modeLatch = chipReset_r && !pinLow
                     && (seq_r == RSC_EXTWAIT || (seq_r == RSC_SETTLE && eTick_r
                     && seqCnt_r == `RSC_SAMPLE_ECYC - 13'h0001));
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_r <= `RSC_MODE_RST;
    end else if (modeLatch) begin
      mode_r <= {dbgSync_r[1], selBSync_r[1], selASync_r[1]};
    end
  end

  // APB decode; index is the word address
  assign idx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);
  always_comb begin
    mapped = aligned;
    case (idx)
      `RSC_IDX_IFB0, `RSC_IDX_IFB1, `RSC_IDX_IFB2, `RSC_IDX_IFB3: mapped = aligned;
      `RSC_IDX_WDSVC, `RSC_IDX_WDCTL, `RSC_IDX_CMCTL: mapped = aligned;
      `RSC_IDX_RSTAT, `RSC_IDX_PRIO: mapped = aligned;
      default: mapped = 1'b0;
    endcase
  end
  assign wrAcc = psel & penable & pwrite & mapped;
  assign wrByte = pwdata[7:0];

  // Watchdog period doubles per rate step; rate zero switches it off
  assign wdEn = (wdRate_r != 3'h0);
  assign wdPeriod = 24'h00_0001 << (5'(WD_BASE_SH) + {2'h0, wdRate_r});
  assign wdWinStart = wdPeriod - (wdPeriod >> 2);

  // Software-writable control; an internal reset restores the start-up values
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wdRate_r <= `RSC_WD_RATE_RST;
      wdWin_r <= 1'b0;
      cmEn_r <= 1'b0;
      topPrio_r <= `RSC_PRIO_RST;
      itst_r <= 32'h0000_0000;
    end else if (chipReset_r) begin
      wdRate_r <= `RSC_WD_RATE_RST;
      wdWin_r <= 1'b0;
      cmEn_r <= 1'b0;
      topPrio_r <= `RSC_PRIO_RST;
      itst_r <= 32'h0000_0000;
    end else if (wrAcc) begin
      case (idx)
        `RSC_IDX_WDCTL: begin
          wdRate_r <= wrByte[2:0];
          wdWin_r <= wrByte[`RSC_WD_WIN_BIT];
        end
        `RSC_IDX_CMCTL: cmEn_r <= wrByte[0];
        `RSC_IDX_PRIO: topPrio_r <= wrByte;
        `RSC_IDX_IFB0: if (specialMode) itst_r[7:0] <= wrByte;
        `RSC_IDX_IFB1: if (specialMode) itst_r[15:8] <= wrByte;
        `RSC_IDX_IFB2: if (specialMode) itst_r[23:16] <= wrByte;
        `RSC_IDX_IFB3: if (specialMode) itst_r[31:24] <= wrByte;
        default: begin
        end
      endcase
    end
  end

  // Watchdog timer and service sequence
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wdCnt_r <= 24'h00_0000;
      wdArmed_r <= 1'b0;
      wdFault_r <= 1'b0;
    end else if (chipReset_r) begin
      wdCnt_r <= 24'h00_0000;
      wdArmed_r <= 1'b0;
      wdFault_r <= 1'b0;
    end else begin
      wdFault_r <= 1'b0;
      if (!wdEn) begin
        wdCnt_r <= 24'h00_0000;
        wdArmed_r <= 1'b0;
      end else if (wrAcc && idx == `RSC_IDX_WDSVC) begin
        wdCnt_r <= wdCnt_r + 24'h00_0001;
        if (wdWin_r && wdCnt_r < wdWinStart) begin
          wdFault_r <= 1'b1;
        end else if (wrByte == `RSC_WD_KEY1) begin
          wdArmed_r <= 1'b1;
        end else if (wrByte == `RSC_WD_KEY2 && wdArmed_r) begin
          wdCnt_r <= 24'h00_0000;
          wdArmed_r <= 1'b0;
        end else begin
          wdFault_r <= 1'b1;
        end
      end else if (wdCnt_r >= wdPeriod - 24'h00_0001) begin
        wdFault_r <= 1'b1;
        wdCnt_r <= 24'h00_0000;
      end else begin
        wdCnt_r <= wdCnt_r + 24'h00_0001;
      end
    end
  end

  // Test view may tear while a request is changing; software reads twice
  assign itstView = specialMode ? (itst_r | moduleIrq) : 32'h0000_0000;

  always_comb begin
    case (idx)
      `RSC_IDX_IFB0: rdVal = {24'h00_0000, itstView[7:0]};
      `RSC_IDX_IFB1: rdVal = {24'h00_0000, itstView[15:8]};
      `RSC_IDX_IFB2: rdVal = {24'h00_0000, itstView[23:16]};
      `RSC_IDX_IFB3: rdVal = {24'h00_0000, itstView[31:24]};
      `RSC_IDX_WDCTL: rdVal = {24'h00_0000, 1'b0, wdWin_r, 3'h0, wdRate_r};
      `RSC_IDX_CMCTL: rdVal = {30'h0000_0000, slowSync_r[1], cmEn_r};
      `RSC_IDX_RSTAT: rdVal = {24'h00_0000, 2'h0, wdArmed_r, mode_r, src_r};
      `RSC_IDX_PRIO: rdVal = {24'h00_0000, topPrio_r};
      default: rdVal = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup cycle so access needs no wait state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_r <= (pwrite || !mapped) ? 32'h0000_0000 : rdVal;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  assign resetPinOut = 1'b0;
  assign resetPinOe = pinDrive_r;
  assign chipReset = chipReset_r;
  assign resetVector = vec_r;
  assign modeBits = mode_r;
  assign forcedIrq = itst_r;
  assign topPriority = topPrio_r;

  // Start-up states, fixed except the port setup taken from mode select A; held for the other blocks to pick up
  logic [7:0] startup_r;
  logic [2:0] portCfg_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      startup_r <= 8'h1E;
      portCfg_r <= 3'h4;
    end else if (chipReset_r) begin
      startup_r <= 8'h1E;
      portCfg_r <= 3'h4;
      // Loaded with the mode so the ports are right on the first run cycle
      if (modeLatch) begin
        portCfg_r <= {~selASync_r[1], selASync_r[1], selASync_r[1]};
      end
    end
  end

  // startup_r: 0 periodic flag, 1 delay, 2 stop off, 3 X mask, 4 I mask
  assign periodicIntFlag = startup_r[0];
  assign stopRecoveryDelay = startup_r[1];
  assign stopDisable = startup_r[2];
  assign xMask = startup_r[3];
  assign iMask = startup_r[4];
  assign irqEdgeSelect = startup_r[5];
  assign periodicRate = 4'h0;
  assign portsAllInputs = portCfg_r[2];
  assign addrDataBusEn = portCfg_r[1];
  assign busControlEn = portCfg_r[0];
  assign regBlockBase = `RSC_REG_BASE;
  assign ramBase = `RSC_RAM_BASE;
  assign eepromBase = `RSC_EE_BASE;
  assign periphEnable = 7'h00;
endmodule
`default_nettype wire

// ===== tb/rsc_ext_circuit.sv
// External reset circuit sharing the open-drain reset pin
`timescale 1ns/10ps
`default_nettype none
module rsc_ext_circuit #(
  parameter int MIN_HOLD = 32
) (
  input wire logic ref_clk,
  input wire logic pullReq,
  input wire logic resetPinOut,
  input wire logic resetPinOe,
  output logic pinLevel
);
  int holdCnt = 0;
  // A pull always lasts long enough not to pass for a watchdog reset
  always @(posedge ref_clk) begin
    if (pullReq) begin
      holdCnt <= MIN_HOLD;
    end else if (holdCnt > 0) begin
      holdCnt <= holdCnt - 1;
    end
  end
  // Pull-up wins only while nobody drives low
  assign pinLevel = !((resetPinOe && !resetPinOut) || holdCnt > 0);
endmodule
`default_nettype wire

// ===== tb/rsc_reset_source_control_props.sv
// Assertion checker for the reset source control
`timescale 1ns/10ps
`default_nettype none
`include "rsc_defs.svh"
module rsc_reset_source_control_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic resetPinOe,
  input wire logic [31:0] forcedIrq,
  input wire logic chipReset,
  input wire logic [1:0] resetVector,
  input wire logic [2:0] modeBits,
  input wire logic addrDataBusEn,
  input wire logic portsAllInputs,
  input wire logic [7:0] topPriority,
  input wire logic xMask,
  input wire logic iMask,
  input wire logic stopDisable,
  input wire logic [6:0] periphEnable
);
  logic [12:0] oeCnt_r;
  logic acc;
  logic itstHit;
  assign acc = psel && penable && !chipReset;
  assign itstHit = paddr[11:4] == 8'h06 && paddr[1:0] == 2'b00;
  // Length of the current low drive on the pin
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      oeCnt_r <= 13'h0000;
    end else begin
      oeCnt_r <= resetPinOe ? oeCnt_r + 13'h0001 : 13'h0000;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  hold_length_a: assert property ($fell(resetPinOe) |-> oeCnt_r inside {[16:17], [4112:4113]})
    else $error("pin hold length wrong");
  late_sample_a: assert property ($fell(resetPinOe) |-> chipReset[*8])
    else $error("reset left before pin sample");
  pin_follows_a: assert property ($rose(chipReset) |-> resetPinOe)
    else $error("internal reset without pin drive");
  normal_read_a: assert property (acc && !pwrite && itstHit && modeBits[2] |-> prdata == 32'h0000_0000)
    else $error("test register read not zero");
  normal_write_a: assert property (acc && pwrite && itstHit && modeBits[2] |=> forcedIrq == 32'h0000_0000)
    else $error("test register took a normal write");
  force_bank_a: assert property (acc && pwrite && paddr == {`RSC_IDX_IFB0, 2'b00} && !modeBits[2]
    |=> forcedIrq[7:0] == $past(pwdata[7:0]))
    else $error("forced bits not written");
  bad_key_a: assert property (acc && pwrite && paddr == {`RSC_IDX_WDSVC, 2'b00}
    && !(pwdata[7:0] inside {8'h55, 8'hAA}) |-> ##[1:3] chipReset)
    else $error("bad service value without reset");
  start_state_a: assert property ($fell(chipReset) |-> topPriority == 8'hF2 && xMask && iMask
    && stopDisable && periphEnable == 7'h00)
    else $error("start-up state wrong");
  port_mode_a: assert property ($fell(chipReset) |-> portsAllInputs == !modeBits[0]
    && addrDataBusEn == modeBits[0])
    else $error("port configuration wrong");
  cover property ($fell(chipReset) && resetVector == 2'b00);
  cover property ($fell(chipReset) && resetVector == 2'b01);
  cover property ($fell(chipReset) && resetVector == 2'b10);
endmodule
bind rsc_reset_source_control rsc_reset_source_control_props u_props (
  .ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .resetPinOe(resetPinOe),
  .forcedIrq(forcedIrq), .chipReset(chipReset), .resetVector(resetVector),
  .modeBits(modeBits), .addrDataBusEn(addrDataBusEn), .portsAllInputs(portsAllInputs),
  .topPriority(topPriority), .xMask(xMask), .iMask(iMask), .stopDisable(stopDisable),
  .periphEnable(periphEnable));
`default_nettype wire

// ===== tb/rsc_reset_source_control_tb.sv
// Self-checking bench for the reset source control
`timescale 1ns/10ps
`default_nettype none
`include "rsc_defs.svh"
module rsc_reset_source_control_tb;
  import rsc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic bgd = 1'b1;
  logic modeA = 1'b0;
  logic modeB = 1'b0;
  logic slowClk = 1'b0;
  logic pullReq = 1'b0;
  logic [31:0] modIrq = 32'h0000_0000;
  logic [31:0] prdata, forcedIrq, rd;
  logic pready, pslverr, pinLevel, resetPinOut, resetPinOe, chipReset, err;
  logic adEn, bcEn, allIn, pif, srd, edgeSel, xm, im, sd;
  logic [1:0] resetVector;
  logic [2:0] modeBits;
  logic [3:0] prate;
  logic [7:0] prio;
  logic [6:0] pe;
  logic [15:0] regBase, ramB, eeB;
  logic [31:0] lfsr = 32'h2c7d;
  int failures = 0;
  int checks = 0;
  int itstModel[4];

  rsc_reset_source_control #(.WD_BASE_SH(2)) DUT (
    .ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .resetPinIn(pinLevel), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
    .backgroundDebugPin(bgd), .modeSelectA(modeA), .modeSelectB(modeB), .clockSlow(slowClk),
    .moduleIrq(modIrq), .forcedIrq(forcedIrq), .chipReset(chipReset),
    .resetVector(resetVector), .modeBits(modeBits), .addrDataBusEn(adEn),
    .busControlEn(bcEn), .portsAllInputs(allIn), .regBlockBase(regBase), .ramBase(ramB),
    .eepromBase(eeB), .periodicIntFlag(pif), .periodicRate(prate), .stopRecoveryDelay(srd),
    .topPriority(prio), .irqEdgeSelect(edgeSel), .xMask(xm), .iMask(im), .stopDisable(sd),
    .periphEnable(pe));
  rsc_ext_circuit ext (.ref_clk(ref_clk), .pullReq(pullReq), .resetPinOut(resetPinOut),
    .resetPinOe(resetPinOe), .pinLevel(pinLevel));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One idle edge first so back-to-back calls never reassign in one step
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic waitLevel(input logic lvl, input int lim);
    int n;
    n = 0;
    while (chipReset !== lvl && n < lim) begin
      n++;
      @(posedge ref_clk);
    end
    check(chipReset, lvl);
  endtask

  task automatic exitCheck(input logic [1:0] vec, input int riseLim);
    waitLevel(1'b1, riseLim);
    waitLevel(1'b0, 6000);
    check(resetVector, vec);
    check(modeBits, {bgd, modeB, modeA});
    check({allIn, adEn, bcEn}, {!modeA, modeA, modeA});
    check({pif, prate, srd}, {1'b0, 4'h0, 1'b1});
    check({prio, edgeSel, xm, im, sd, pe}, {8'hF2, 4'b0111, 7'h00});
    check({regBase, ramB, eeB}, {16'h0000, 16'h2000, 16'h0800});
  endtask

  initial begin
    repeat (30000) @(posedge ref_clk);
    failures++;
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    exitCheck(2'b00, 5);
    apb(1'b1, `RSC_IDX_IFB0, 8'hFF);
    check(forcedIrq, 32'h0000_0000);
    apb(1'b0, `RSC_IDX_IFB0, 8'h00);
    check(rd, 32'h0000_0000);
    apb(1'b0, 10'h3FF, 8'h00);
    check({err, rd}, {1'b1, 32'h0000_0000});
    $display("test normal_mode done");
    repeat (3) begin
      repeat (300) @(posedge ref_clk);
      apb(1'b1, `RSC_IDX_WDSVC, 8'h55);
      apb(1'b1, `RSC_IDX_IFB3, 8'h00);
      apb(1'b1, `RSC_IDX_WDSVC, 8'hAA);
    end
    check(chipReset, 1'b0);
    apb(1'b1, `RSC_IDX_WDSVC, 8'h13);
    exitCheck(2'b01, 5);
    exitCheck(2'b01, 1100);
    $display("test watchdog done");
    apb(1'b1, `RSC_IDX_WDCTL, 8'h47);
    apb(1'b1, `RSC_IDX_WDSVC, 8'h55);
    exitCheck(2'b01, 5);
    apb(1'b1, `RSC_IDX_WDCTL, 8'h47);
    repeat (420) @(posedge ref_clk);
    apb(1'b1, `RSC_IDX_WDSVC, 8'h55);
    apb(1'b1, `RSC_IDX_WDSVC, 8'hAA);
    repeat (20) @(posedge ref_clk);
    check(chipReset, 1'b0);
    $display("test window done");
    apb(1'b1, `RSC_IDX_CMCTL, 8'h01);
    slowClk <= 1'b1;
    repeat (4) @(posedge ref_clk);
    slowClk <= 1'b0;
    exitCheck(2'b10, 10);
    $display("test clock_monitor done");
    pullReq <= 1'b1;
    @(posedge ref_clk);
    pullReq <= 1'b0;
    exitCheck(2'b00, 10);
    // Pin still held at the sample: the chip waits for the outside circuit
    pullReq <= 1'b1;
    repeat (40) @(posedge ref_clk);
    pullReq <= 1'b0;
    exitCheck(2'b00, 10);
    apb(1'b0, `RSC_IDX_RSTAT, 8'h00);
    check(rd[1:0], 2'b01);
    $display("test external_pin done");
    bgd <= 1'b0;
    modeA <= 1'b1;
    rst <= 1'b1;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    exitCheck(2'b00, 5);
    for (int b = 0; b < 4; b++) begin
      lfsr = lfsrNext(lfsr);
      itstModel[b] = lfsr[7:0];
      apb(1'b1, `RSC_IDX_IFB0 + 10'(b), lfsr[7:0]);
    end
    for (int b = 0; b < 4; b++) begin
      apb(1'b0, `RSC_IDX_IFB0 + 10'(b), 8'h00);
      check(rd, itstModel[b]);
      check(forcedIrq[b*8 +: 8], itstModel[b]);
    end
    apb(1'b1, `RSC_IDX_IFB2, 8'h00);
    lfsr = lfsrNext(lfsr);
    modIrq <= {8'h00, lfsr[7:0], 16'h0000};
    apb(1'b0, `RSC_IDX_IFB2, 8'h00);
    check(rd, lfsr[7:0]);
    $display("test special_mode done");
    print_verdict();
  end
endmodule
`default_nettype wire
